// ### arpsc_top.sv
`timescale 1ns/1ps
module arpsc_top #(
  parameter int LOCKOUT = arpsc_pkg::LOCKOUT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hard_reset_n,
  input wire logic convert_strobe,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic busy,
  output logic standby,
  output logic shutdown,
  output logic ref_ready,
  output logic low_voltage_drive_boost,
  output logic locked,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rst_sync;
    logic rst_prev;
    logic [1:0] cnv_sync;
    logic cnv_prev;
    arpsc_pkg::arpsc_state_e state;
    logic [arpsc_pkg::CNT_W-1:0] cnt;
    logic [arpsc_pkg::CNT_W-1:0] settle;
    logic [1:0] pstate_shadow;
    logic boost_shadow;
    logic [1:0] pstate;
    logic boost;
    logic reset_seen_flag;
    logic [arpsc_pkg::IRQ_WIDTH-1:0] status;
    logic [arpsc_pkg::IRQ_WIDTH-1:0] mask;
    logic [7:0] rdata;
    logic busy;
    logic irq;
    logic standby;
    logic shutdown;
    logic locked;
    logic ref_ready;
  } arpsc_regs_s;

  arpsc_regs_s r;
  arpsc_regs_s next_r;

  logic hard_fall;
  logic soft_req;
  logic do_reset;
  logic cnv_rise;
  logic conv_done;
  logic lock_end;
  logic [arpsc_pkg::IRQ_WIDTH-1:0] events;

  localparam logic [arpsc_pkg::CNT_W-1:0] LOCK_LAST =
    arpsc_pkg::CNT_W'(LOCKOUT - 1);
  localparam logic [arpsc_pkg::CNT_W-1:0] CONV_LAST =
    arpsc_pkg::CNT_W'(arpsc_pkg::CONV_CYCLES - 1);
  localparam logic [arpsc_pkg::CNT_W-1:0] SETTLE_LOAD =
    arpsc_pkg::CNT_W'(arpsc_pkg::SETTLE_CYCLES);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rst_sync = {r.rst_sync[0], hard_reset_n};
    next_r.rst_prev = r.rst_sync[1];
    next_r.cnv_sync = {r.cnv_sync[0], convert_strobe};
    next_r.cnv_prev = r.cnv_sync[1];
    hard_fall = r.rst_prev && !r.rst_sync[1];
    soft_req = wr && (addr == arpsc_pkg::ADDR_IFACE_CFG) &&
      (r.state != arpsc_pkg::ARPSC_LOCKED) &&
      wdata[arpsc_pkg::SOFT_RESET_POS] &&
      wdata[arpsc_pkg::SOFT_RESET_CONFIRM_POS];
    do_reset = hard_fall || soft_req;
    cnv_rise = r.cnv_sync[1] && !r.cnv_prev;
    conv_done = 1'b0;
    lock_end = 1'b0;
    next_r.rdata = 8'h00;

    if (r.settle != '0) begin
      next_r.settle = r.settle - 1'b1;
    end

    unique case (r.state)
      arpsc_pkg::ARPSC_LOCKED: begin
        // Held while the pin is low; counts from the clean release
        if (!r.rst_sync[1]) begin
          next_r.cnt = '0;
        end else if (r.cnt == LOCK_LAST) begin
          lock_end = 1'b1;
          next_r.cnt = '0;
          next_r.state = (r.pstate == arpsc_pkg::PSTATE_SHUTDOWN) ?
            arpsc_pkg::ARPSC_SHUTDOWN : arpsc_pkg::ARPSC_STANDBY;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      arpsc_pkg::ARPSC_STANDBY: begin
        if (r.pstate == arpsc_pkg::PSTATE_SHUTDOWN) begin
          next_r.state = arpsc_pkg::ARPSC_SHUTDOWN;
        end else if (cnv_rise) begin
          next_r.busy = 1'b1;
          next_r.cnt = '0;
          next_r.state = arpsc_pkg::ARPSC_CONVERT;
        end
      end
      arpsc_pkg::ARPSC_CONVERT: begin
        if (r.cnt == CONV_LAST) begin
          conv_done = 1'b1;
          next_r.busy = 1'b0;
          next_r.state = arpsc_pkg::ARPSC_STANDBY;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      arpsc_pkg::ARPSC_SHUTDOWN: begin
        if (r.pstate != arpsc_pkg::PSTATE_SHUTDOWN) begin
          next_r.settle = SETTLE_LOAD;
          next_r.state = arpsc_pkg::ARPSC_STANDBY;
        end
      end
      default: begin
        next_r.state = arpsc_pkg::ARPSC_LOCKED;
      end
    endcase

    // Register writes, blocked during lockout
    if (wr && r.state != arpsc_pkg::ARPSC_LOCKED) begin
      unique case (addr)
        arpsc_pkg::ADDR_DEV_CFG: next_r.pstate_shadow = wdata[1:0];
        arpsc_pkg::ADDR_DRIVE_CFG:
          next_r.boost_shadow = wdata[arpsc_pkg::BOOST_POS];
        arpsc_pkg::ADDR_IRQ_MASK:
          next_r.mask = wdata[arpsc_pkg::IRQ_WIDTH-1:0];
        arpsc_pkg::ADDR_EXIT_CFG: begin
          if (wdata == arpsc_pkg::EXIT_CFG_VALUE) begin
            next_r.pstate = r.pstate_shadow;
            next_r.boost = r.boost_shadow;
          end
        end
        default: ;
      endcase
    end

    // Reads
    if (rd) begin
      unique case (addr)
        arpsc_pkg::ADDR_DEV_CFG: next_r.rdata = {6'h00, r.pstate_shadow};
        arpsc_pkg::ADDR_DIAG: next_r.rdata = {7'h00, r.reset_seen_flag};
        arpsc_pkg::ADDR_DRIVE_CFG: next_r.rdata = {7'h00, r.boost_shadow};
        arpsc_pkg::ADDR_IRQ_STATUS: next_r.rdata = {5'h00, r.status};
        arpsc_pkg::ADDR_IRQ_MASK: next_r.rdata = {5'h00, r.mask};
        arpsc_pkg::ADDR_STATE: next_r.rdata = {4'h0, r.state};
        default: next_r.rdata = 8'h00;
      endcase
    end

    // Sticky flag: clear by one, set wins
    if (wr && addr == arpsc_pkg::ADDR_DIAG &&
        wdata[arpsc_pkg::RESET_SEEN_POS]) begin
      next_r.reset_seen_flag = 1'b0;
    end
    events = '0;
    events[arpsc_pkg::IRQ_RESET_POS] = do_reset;
    events[arpsc_pkg::IRQ_DONE_POS] = conv_done;
    events[arpsc_pkg::IRQ_LOCK_END_POS] = lock_end;
    if (wr && addr == arpsc_pkg::ADDR_IRQ_STATUS) begin
      next_r.status = r.status & ~wdata[arpsc_pkg::IRQ_WIDTH-1:0];
    end
    next_r.status = next_r.status | events;

    // Full reset restores defaults, keeps the interrupt mask
    if (do_reset) begin
      next_r.pstate_shadow = arpsc_pkg::PSTATE_RESET;
      next_r.pstate = arpsc_pkg::PSTATE_RESET;
      next_r.boost_shadow = 1'b0;
      next_r.boost = 1'b0;
      next_r.busy = 1'b0;
      next_r.settle = '0;
      next_r.cnt = '0;
      next_r.state = arpsc_pkg::ARPSC_LOCKED;
      next_r.reset_seen_flag = 1'b1;
    end
    next_r.irq = |(next_r.status & next_r.mask);
    // State decodes are registered so that every output comes from a flop
    next_r.standby = (next_r.state == arpsc_pkg::ARPSC_STANDBY);
    next_r.shutdown = (next_r.state == arpsc_pkg::ARPSC_SHUTDOWN);
    next_r.locked = (next_r.state == arpsc_pkg::ARPSC_LOCKED);
    next_r.ref_ready = (next_r.settle == '0) && !next_r.shutdown;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
      r.rst_sync <= 2'h3;
      r.rst_prev <= 1'b1;
      r.state <= arpsc_pkg::ARPSC_STANDBY;
      r.pstate <= arpsc_pkg::PSTATE_RESET;
      r.pstate_shadow <= arpsc_pkg::PSTATE_RESET;
      r.mask <= arpsc_pkg::MASK_RESET[arpsc_pkg::IRQ_WIDTH-1:0];
      r.reset_seen_flag <= 1'b1;
      r.status <= 3'h1;
      r.standby <= 1'b1;
      r.ref_ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign busy = r.busy;
  assign standby = r.standby;
  assign shutdown = r.shutdown;
  assign ref_ready = r.ref_ready;
  assign low_voltage_drive_boost = r.boost;
  assign locked = r.locked;
  assign irq = r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  soft_reset_both_a: assert property (
    (wr && addr == arpsc_pkg::ADDR_IFACE_CFG && !locked &&
     !(wdata[0] && wdata[7]) && !hard_fall) |=> !locked)
    else $error("soft reset without both bits");
  reset_sets_flag_a: assert property (
    do_reset |=> r.reset_seen_flag && locked)
    else $error("reset did not set flag");
  flag_clear_one_a: assert property (
    (r.reset_seen_flag && !do_reset &&
     !(wr && addr == arpsc_pkg::ADDR_DIAG && wdata[0]))
    |=> r.reset_seen_flag)
    else $error("flag lost without write of one");
  lock_no_conv_a: assert property (
    locked |-> !busy)
    else $error("conversion during lockout");
  lock_blocks_cfg_a: assert property (
    (locked && wr && addr == arpsc_pkg::ADDR_EXIT_CFG && !do_reset)
    |=> $stable(r.pstate))
    else $error("write accepted in lockout");
  standby_after_a: assert property (
    $fell(busy) && !$past(do_reset) |-> standby)
    else $error("no standby after conversion");
  busy_rise_a: assert property (
    (standby && cnv_rise && r.pstate != arpsc_pkg::PSTATE_SHUTDOWN &&
     !do_reset) |=> busy ##30 !busy)
    else $error("busy width wrong");
  shutdown_enter_a: assert property (
    (standby && r.pstate == arpsc_pkg::PSTATE_SHUTDOWN && !do_reset)
    |=> shutdown)
    else $error("shutdown not entered");
  exit_applies_a: assert property (
    (wr && addr == arpsc_pkg::ADDR_EXIT_CFG &&
     wdata == arpsc_pkg::EXIT_CFG_VALUE && !locked && !do_reset)
    |=> r.pstate == $past(r.pstate_shadow))
    else $error("exit did not apply");
  irq_level_a: assert property (
    irq == |(r.status & r.mask))
    else $error("irq mismatch");
  boost_applies_a: assert property (
    (wr && addr == arpsc_pkg::ADDR_EXIT_CFG &&
     wdata == arpsc_pkg::EXIT_CFG_VALUE && !locked && !do_reset)
    |=> r.boost == $past(r.boost_shadow))
    else $error("exit did not apply boost");
  settle_wait_a: assert property (
    $fell(shutdown) && !$past(do_reset) |-> !ref_ready)
    else $error("reference ready too soon");
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");

  conv_cov: cover property (cnv_rise && standby ##1 busy);
  reset_cov: cover property (hard_fall ##[1:5] locked);
  shut_cov: cover property (shutdown ##[1:20] standby);
  soft_cov: cover property (soft_req ##1 locked);
  unlock_cov: cover property (lock_end ##1 standby);

endmodule : arpsc_top

// ### arpsc_pkg.sv
package arpsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IFACE_CFG = 8'h00;
  localparam logic [7:0] ADDR_DEV_CFG = 8'h02;
  localparam logic [7:0] ADDR_DIAG = 8'h04;
  localparam logic [7:0] ADDR_DRIVE_CFG = 8'h06;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0a;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  localparam logic [7:0] ADDR_EXIT_CFG = 8'h14;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int SOFT_RESET_POS = 0;
  localparam int SOFT_RESET_CONFIRM_POS = 7;
  localparam int RESET_SEEN_POS = 0;
  localparam int BOOST_POS = 0;
  localparam logic [7:0] EXIT_CFG_VALUE = 8'h01;
  localparam logic [1:0] PSTATE_NORMAL = 2'h0;
  localparam logic [1:0] PSTATE_SHUTDOWN = 2'h3;
  localparam logic [1:0] PSTATE_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Interrupt status bits
  localparam int IRQ_RESET_POS = 0;
  localparam int IRQ_DONE_POS = 1;
  localparam int IRQ_LOCK_END_POS = 2;
  localparam int IRQ_WIDTH = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int LOCKOUT_US = 750;
  localparam int LOCKOUT_CYCLES = LOCKOUT_US * CLK_MHZ;
  localparam int CONV_NS = 300;
  localparam int CONV_CYCLES = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_US = 30;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 17;

  typedef enum logic [3:0] {
    ARPSC_LOCKED = 4'b0001,
    ARPSC_STANDBY = 4'b0010,
    ARPSC_CONVERT = 4'b0100,
    ARPSC_SHUTDOWN = 4'b1000
  } arpsc_state_e;

endpackage : arpsc_pkg

// ### arpsc_host_model.sv
`timescale 1ns/1ps
module arpsc_host_model #(
  parameter int STARTUP_CYC = 4
) (
  input wire logic mclk,
  input wire logic busy,
  output logic hard_reset_n,
  output logic convert_strobe,
  output logic [1:0] mux_sel
);
  int up_cnt = 0;
  initial begin
    hard_reset_n = 1'b1;
    convert_strobe = 1'b0;
    mux_sel = 2'h0;
  end
  always @(posedge mclk) begin
    up_cnt <= up_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Host actions
  // ----------------------------------------------------------------
  task automatic hard_pulse(input int width);
    while (up_cnt < STARTUP_CYC) @(posedge mclk);
    @(posedge mclk);
    hard_reset_n <= 1'b0;
    repeat ((width < 5) ? 5 : width) @(posedge mclk);
    hard_reset_n <= 1'b1;
  endtask : hard_pulse
  task automatic convert();
    @(posedge mclk);
    convert_strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    convert_strobe <= 1'b0;
  endtask : convert
  // Mux moves once the conversion is over, or after 100 cycles of waiting on busy
  task automatic switch_mux(input logic [1:0] ch);
    int n = 0;
    @(posedge mclk);
    while (busy !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    mux_sel <= ch;
  endtask : switch_mux
endmodule : arpsc_host_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
  localparam int LOCK = 50;
  localparam logic [7:0] A_IF = arpsc_pkg::ADDR_IFACE_CFG;
  localparam logic [7:0] A_DEV = arpsc_pkg::ADDR_DEV_CFG;
  localparam logic [7:0] A_DIAG = arpsc_pkg::ADDR_DIAG;
  localparam logic [7:0] A_ST = arpsc_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_EXIT = arpsc_pkg::ADDR_EXIT_CFG;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hard_reset_n, convert_strobe, busy, standby, shutdown;
  logic ref_ready, boost, locked, irq;
  logic [7:0] rdata;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  time t0;
  always #5 mclk = ~mclk;
  arpsc_top #(.LOCKOUT(LOCK)) arpsc_top_inst (.mclk(mclk), .rst(rst),
    .hard_reset_n(hard_reset_n), .convert_strobe(convert_strobe),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .busy(busy), .standby(standby), .shutdown(shutdown),
    .ref_ready(ref_ready), .low_voltage_drive_boost(boost),
    .locked(locked), .irq(irq));
  arpsc_host_model arpsc_host_model_inst (.mclk(mclk), .busy(busy),
    .hard_reset_n(hard_reset_n), .convert_strobe(convert_strobe),
    .mux_sel());
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("tb: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  // Waits on locked (0), busy (1) or ref_ready (2), counting cycles
  task automatic wait_on(input int sel, input logic v, output int c);
    c = 0;
    while (((sel == 0) ? locked : (sel == 1) ? busy : ref_ready) !== v) begin
      tick(1);
      c++;
      if (c > 4000) begin
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        complete_run();
      end
    end
  endtask : wait_on
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_por();
    rd_chk(A_DIAG, 8'h01);
    rd_chk(A_DEV, 8'h00);
    rd_chk(arpsc_pkg::ADDR_STATE, 8'(arpsc_pkg::ARPSC_STANDBY));
    chk({7'h0, shutdown}, 8'h00);
    wr_reg(A_DIAG, 8'h00);
    rd_chk(A_DIAG, 8'h01);
    wr_reg(A_DIAG, 8'h01);
    rd_chk(A_DIAG, 8'h00);
    rd_chk(8'h30, 8'h00);
    $display("t_por done");
  endtask : t_por
  task automatic t_hard();
    arpsc_host_model_inst.hard_pulse(5);
    wait_on(0, 1'b1, n);
    t0 = $time;
    wr_reg(A_DEV, 8'h03);
    wr_reg(A_EXIT, 8'h01);
    arpsc_host_model_inst.convert();
    tick(6);
    chk({7'h0, busy}, 8'h00);
    wait_on(0, 1'b0, n);
    n = int'(($time - t0) / 10);
    chk({6'h0, n >= LOCK, n <= LOCK + 12}, 8'h03);
    chk({7'h0, shutdown}, 8'h00);
    rd_chk(A_DIAG, 8'h01);
    $display("t_hard done");
  endtask : t_hard
  task automatic t_soft();
    wr_reg(A_DIAG, 8'h01);
    wr_reg(A_ST, 8'h07);
    wr_reg(A_IF, 8'h01);
    tick(3);
    chk({7'h0, locked}, 8'h00);
    wr_reg(A_IF, 8'h80);
    tick(3);
    chk({7'h0, locked}, 8'h00);
    wr_reg(A_IF, 8'h81);
    tick(3);
    chk({7'h0, locked}, 8'h01);
    wait_on(0, 1'b0, n);
    rd_chk(A_DIAG, 8'h01);
    // Reset event and end of lockout both latched
    rd_chk(A_ST, 8'h05);
    $display("t_soft done");
  endtask : t_soft
  task automatic t_conv();
    wr_reg(A_ST, 8'h07);
    wr_reg(arpsc_pkg::ADDR_IRQ_MASK, 8'h02);
    tick(2);
    chk({7'h0, irq}, 8'h00);
    arpsc_host_model_inst.convert();
    wait_on(1, 1'b1, n);
    wait_on(1, 1'b0, n);
    // Busy rose one cycle before the strobe task returned
    chk(8'(n + 1), 8'(arpsc_pkg::CONV_CYCLES));
    tick(2);
    chk({6'h0, standby, irq}, 8'h03);
    rd_chk(A_ST, 8'h02);
    rd_chk(arpsc_pkg::ADDR_IRQ_MASK, 8'h02);
    wr_reg(A_ST, 8'h02);
    tick(2);
    chk({7'h0, irq}, 8'h00);
    arpsc_host_model_inst.convert();
    arpsc_host_model_inst.switch_mux(2'h1);
    $display("t_conv done");
  endtask : t_conv
  task automatic t_shut();
    wr_reg(A_DEV, 8'h03);
    tick(2);
    chk({7'h0, shutdown}, 8'h00);
    wr_reg(A_EXIT, 8'h01);
    tick(2);
    chk({6'h0, shutdown, ref_ready}, 8'h02);
    arpsc_host_model_inst.convert();
    tick(6);
    chk({7'h0, busy}, 8'h00);
    wr_reg(A_DEV, 8'h00);
    wr_reg(A_EXIT, 8'h01);
    tick(2);
    chk({6'h0, shutdown, ref_ready}, 8'h00);
    wait_on(2, 1'b1, n);
    chk({6'h0, n >= arpsc_pkg::SETTLE_CYCLES - 10,
      n <= arpsc_pkg::SETTLE_CYCLES}, 8'h03);
    wr_reg(arpsc_pkg::ADDR_DRIVE_CFG, 8'h01);
    wr_reg(A_EXIT, 8'h01);
    tick(2);
    chk({7'h0, boost}, 8'h01);
    $display("t_shut done");
  endtask : t_shut
  // Power-on reset in mid-run restores defaults
  task automatic t_mid_rst();
    wr_reg(A_DIAG, 8'h01);
    wr_reg(A_DEV, 8'h03);
    wr_reg(arpsc_pkg::ADDR_DRIVE_CFG, 8'h01);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(A_DEV, 8'h00);
    rd_chk(arpsc_pkg::ADDR_DRIVE_CFG, 8'h00);
    rd_chk(A_DIAG, 8'h01);
    chk({7'h0, boost}, 8'h00);
    $display("t_mid_rst done");
  endtask : t_mid_rst
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_por();
    t_hard();
    t_soft();
    t_conv();
    t_shut();
    t_mid_rst();
    complete_run();
  end
endmodule : tb
